// ### hw/wdr_pkg.sv
`default_nettype none
package wdr_pkg;
    // ==========================================
    // bus geometry and register map
    localparam int WB_DW = 32;
    localparam int WB_AW = 4;
    localparam logic [3:0] WDC_OFS = 4'h0; // watchdog_control
    localparam logic [3:0] RFC_OFS = 4'h4; // reset_flag_control
    localparam logic [3:0] STS_OFS = 4'h8; // timeout / power-down status

    // ==========================================
    // watchdog_control fields
    localparam int KEY_MSB = 7;
    localparam int KEY_LSB = 3;
    localparam int SEL_MSB = 2;
    localparam int SEL_LSB = 0;
    localparam logic [7:0] WDC_RST = 8'h53;
    localparam logic [4:0] KEY_EN = 5'h0a;
    localparam logic [4:0] KEY_DIS = 5'h15;

    // ==========================================
    // reset_flag_control and status fields
    localparam int WRF_BIT = 0;
    localparam int LRF_BIT = 1;
    localparam int LOW_VOLTAGE_RESET_FLAG_BIT = 2;
    localparam int KEEP_BIT = 7;
    localparam int PDF_BIT = 0;
    localparam int TO_BIT = 1;

    // ==========================================
    // timing
    localparam int CNT_W = 18;
    localparam int HOLD_W = 20;
    localparam int DIV_EXP [8] = '{8, 10, 12, 14, 15, 16, 17, 18};
    localparam logic [1:0] KEY_RST_TICKS = 2'h3; // low-speed rc cycles
    localparam int CLK_HZ = 10000000;
    localparam int POR_DELAY_MS = 50;
    localparam int POR_DELAY_CYC = POR_DELAY_MS * (CLK_HZ / 1000);

    // terminal count for a timeout select code
    function automatic logic [CNT_W-1:0] wdt_limit(input logic [2:0] sel);
        logic [31:0] full;
        full = (32'h1 << DIV_EXP[sel]) - 32'h1;
        return full[CNT_W-1:0];
    endfunction
endpackage
`default_nettype wire

// ### hw/wdr_tick.sv
`default_nettype none
// ==========================================
// slow clock sampler: two-flop synchroniser and rising edge pulse
module wdr_tick (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic SRC_CLK,
    output logic TICK
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } wdr_tick_t;

    wdr_tick_t st_reg;
    wdr_tick_t st_next;

    // shift the sampled level along
    always_comb begin
        st_next = st_reg;
        st_next.s1 = SRC_CLK;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    // registers, frozen while enable is low
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            st_reg <= '0;
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    // one pulse per rising edge, looks only past the first flop
    assign TICK = st_reg.s2 && !st_reg.s3;
endmodule
`default_nettype wire

// ### hw/wdr_top.sv
// The implementer's own choices: the Wishbone register port and the address map.
`default_nettype none
module wdr_top #(
    parameter int POR_DELAY_CYC = wdr_pkg::POR_DELAY_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [wdr_pkg::WB_AW-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [wdr_pkg::WB_DW-1:0] WB_DAT_I,
    output logic [wdr_pkg::WB_DW-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic LOW_SPEED_CRYSTAL,
    input wire logic LOW_SPEED_RC_OSC,
    input wire logic SUB_SRC_XTAL,
    input wire logic CLEAR_WATCHDOG_INSTR,
    input wire logic HALT_INSTR,
    input wire logic SLEEP_MODE,
    input wire logic EXTERNAL_RESET_PIN_N,
    input wire logic LOW_VOLTAGE_RESET,
    input wire logic LVR_KEY_RESET,
    output logic CORE_RST,
    output logic PC_SP_CLR,
    output logic PORT_PRESET,
    output logic TIMEOUT_FLAG,
    output logic POWER_DOWN_FLAG,
    output logic IDLE_SYSCLK_KEEP
);
    import wdr_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        logic [7:0] wdc;
        logic keep;
        logic low_voltage_reset_flag;
        logic lvr_key_reset_flag;
        logic watchdog_key_reset_flag;
        logic to_flag;
        logic power_down_flag;
        logic [CNT_W-1:0] cnt;
        logic key_pend;
        logic [1:0] key_ticks;
        logic [HOLD_W-1:0] hold;
        logic por;
        logic rst;
        logic pcsp;
        logic ack;
        logic [7:0] dat;
    } wdr_state_t;

    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(POR_DELAY_CYC);

    wdr_state_t st_reg;
    wdr_state_t st_next;

    logic xtal_tick;
    logic low_speed_rc_osc_tick;
    logic sub_tick;
    logic [4:0] key;
    logic wdt_on;
    logic key_bad;
    logic key_fire;
    logic timeout;
    logic to_full;
    logic to_sleep;
    logic fire;
    logic cnt_clr;
    logic req;
    logic wr_wdc;
    logic wr_rfc;
    logic [7:0] rfc_val;
    logic [7:0] sts_val;
    logic [7:0] rd_val;

    // ==========================================
    // slow clock samplers
    // each slow clock passes two flops before its edge is used
    wdr_tick u_xtal (
        .MCLK(MCLK),
        .RST_N(RST_N),
        .CE(CE),
        .SRC_CLK(LOW_SPEED_CRYSTAL),
        .TICK(xtal_tick)
    );
    wdr_tick u_low_speed_rc_osc (
        .MCLK(MCLK),
        .RST_N(RST_N),
        .CE(CE),
        .SRC_CLK(LOW_SPEED_RC_OSC),
        .TICK(low_speed_rc_osc_tick)
    );

    // sub clock source picked by a fixed option strap
    assign sub_tick = SUB_SRC_XTAL ? xtal_tick : low_speed_rc_osc_tick;

    // ==========================================
    // watchdog decode
    // key field decode; only the two patterns are legal
    assign key = st_reg.wdc[KEY_MSB:KEY_LSB];
    assign wdt_on = (key == KEY_EN) && !st_reg.rst;
    assign key_bad = (key != KEY_EN) && (key != KEY_DIS);

    // bad key fires on the third rc edge seen after it appeared
    assign key_fire = st_reg.key_pend && low_speed_rc_osc_tick
        && (st_reg.key_ticks == KEY_RST_TICKS - 2'h1);

    // timeout at the selected terminal count
    assign timeout = wdt_on && sub_tick
        && (st_reg.cnt == wdt_limit(st_reg.wdc[SEL_MSB:SEL_LSB]));
    assign to_full = timeout && !SLEEP_MODE;
    assign to_sleep = timeout && SLEEP_MODE;

    // any full device reset request
    assign fire = key_fire || to_full || LOW_VOLTAGE_RESET || LVR_KEY_RESET
        || !EXTERNAL_RESET_PIN_N;

    // events that restart the count
    assign cnt_clr = key_fire || CLEAR_WATCHDOG_INSTR || HALT_INSTR
        || !EXTERNAL_RESET_PIN_N || timeout || fire;

    // ==========================================
    // bus decode
    // write lands on the edge where the master samples ack
    assign req = WB_CYC_I && WB_STB_I;
    assign wr_wdc = req && WB_WE_I && st_reg.ack && WB_SEL_I[0]
        && (WB_ADR_I == WDC_OFS);
    assign wr_rfc = req && WB_WE_I && st_reg.ack && WB_SEL_I[0]
        && (WB_ADR_I == RFC_OFS);

    // read views; unused bits read zero
    assign rfc_val = {st_reg.keep, 4'h0, st_reg.low_voltage_reset_flag, st_reg.lvr_key_reset_flag, st_reg.watchdog_key_reset_flag};
    assign sts_val = {6'h00, st_reg.to_flag, st_reg.power_down_flag};
    assign rd_val = (WB_ADR_I == WDC_OFS) ? st_reg.wdc :
                    (WB_ADR_I == RFC_OFS) ? rfc_val :
                    (WB_ADR_I == STS_OFS) ? sts_val : 8'h00;

    // ==========================================
    // next state
    always_comb begin
        st_next = st_reg;

        // bus slave: one wait cycle, ack for one cycle
        st_next.ack = req && !st_reg.ack;
        if (req && !st_reg.ack) begin
            st_next.dat = rd_val;
        end
        if (wr_wdc) begin
            st_next.wdc = WB_DAT_I[7:0];
        end

        // software may only clear the reset flags
        if (wr_rfc) begin
            st_next.keep = WB_DAT_I[KEEP_BIT];
            if (!WB_DAT_I[WRF_BIT]) begin
                st_next.watchdog_key_reset_flag = 1'b0;
            end
            if (!WB_DAT_I[LRF_BIT]) begin
                st_next.lvr_key_reset_flag = 1'b0;
            end
            if (!WB_DAT_I[LOW_VOLTAGE_RESET_FLAG_BIT]) begin
                st_next.low_voltage_reset_flag = 1'b0;
            end
        end

        // hardware sets come after the clear and win
        if (key_fire) begin
            st_next.watchdog_key_reset_flag = 1'b1;
        end
        if (LOW_VOLTAGE_RESET) begin
            st_next.low_voltage_reset_flag = 1'b1;
        end
        if (LVR_KEY_RESET) begin
            st_next.lvr_key_reset_flag = 1'b1;
        end

        // status flags: clear instruction, halt, timeout
        if (CLEAR_WATCHDOG_INSTR) begin
            st_next.to_flag = 1'b0;
            st_next.power_down_flag = 1'b0;
        end
        if (HALT_INSTR) begin
            st_next.to_flag = 1'b0;
            st_next.power_down_flag = 1'b1;
        end
        if (timeout) begin
            st_next.to_flag = 1'b1;
        end

        // bad key pending: count rc edges
        if (key_bad && !st_reg.key_pend) begin
            st_next.key_pend = 1'b1;
            st_next.key_ticks = 2'h0;
        end else if (st_reg.key_pend && low_speed_rc_osc_tick) begin
            st_next.key_ticks = st_reg.key_ticks + 2'h1;
        end

        // counter runs on sub clock ticks when enabled
        if (cnt_clr) begin
            st_next.cnt = '0;
        end else if (wdt_on && sub_tick) begin
            st_next.cnt = st_reg.cnt + CNT_W'(1'b1);
        end

        // sleep timeout only clears pc and sp
        st_next.pcsp = to_sleep;

        // full reset reloads control and the hold delay
        if (fire) begin
            st_next.wdc = WDC_RST;
            st_next.key_pend = 1'b0;
            st_next.key_ticks = 2'h0;
            st_next.hold = HOLD_LOAD;
        end else if (st_reg.hold != '0) begin
            st_next.hold = st_reg.hold - HOLD_W'(1'b1);
        end
        st_next.rst = (st_next.hold != '0);
        st_next.por = st_reg.por && st_next.rst;
    end

    // ==========================================
    // registers
    // power-on state: enable key, hold loaded, port preset on
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            st_reg <= '0;
            st_reg.wdc <= WDC_RST;
            st_reg.hold <= HOLD_LOAD;
            st_reg.por <= 1'b1;
            st_reg.rst <= 1'b1;
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    // ==========================================
    // outputs
    assign WB_ACK_O = st_reg.ack;
    assign WB_DAT_O = {{(WB_DW - 8){1'b0}}, st_reg.dat};
    assign CORE_RST = st_reg.rst;
    assign PC_SP_CLR = st_reg.rst || st_reg.pcsp;
    assign PORT_PRESET = st_reg.por;
    assign TIMEOUT_FLAG = st_reg.to_flag;
    assign POWER_DOWN_FLAG = st_reg.power_down_flag;
    assign IDLE_SYSCLK_KEEP = st_reg.keep;

    // ==========================================
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    key_reset_fire_a: assert property (
        CE && st_reg.key_pend && low_speed_rc_osc_tick && st_reg.key_ticks == 2'h2
        |=> CORE_RST && st_reg.watchdog_key_reset_flag && st_reg.wdc == WDC_RST)
        else $error("bad key did not reset and flag");

    key_flag_hold_a: assert property (
        $fell(st_reg.watchdog_key_reset_flag) |-> $past(wr_rfc && !WB_DAT_I[WRF_BIT]))
        else $error("key flag cleared without software write");

    disabled_count_a: assert property (
        CE && key == KEY_DIS && !cnt_clr |=> st_reg.cnt == $past(st_reg.cnt)
            && !$rose(st_reg.to_flag))
        else $error("disabled watchdog moved");

    timeout_count_a: assert property (
        CE && wdt_on && sub_tick
            && st_reg.wdc[SEL_MSB:SEL_LSB] == 3'h0 && st_reg.cnt == 18'h000ff
        |=> st_reg.to_flag && st_reg.cnt == '0)
        else $error("2^8 timeout not at count 255");

    run_timeout_a: assert property (
        CE && timeout && !SLEEP_MODE |=> CORE_RST && TIMEOUT_FLAG
            && st_reg.hold == HOLD_LOAD)
        else $error("running timeout missed reset");

    sleep_timeout_a: assert property (
        CE && timeout && SLEEP_MODE && !fire && !st_reg.rst
        |=> PC_SP_CLR && TIMEOUT_FLAG && !CORE_RST ##1 !PC_SP_CLR)
        else $error("sleep timeout wrong effect");

    clear_count_a: assert property (
        CE && (CLEAR_WATCHDOG_INSTR || HALT_INSTR || !EXTERNAL_RESET_PIN_N)
        |=> st_reg.cnt == '0)
        else $error("counter not cleared");

    halt_flags_a: assert property (
        CE && HALT_INSTR && !timeout |=> POWER_DOWN_FLAG && !TIMEOUT_FLAG)
        else $error("halt flags wrong");

    unused_bits_a: assert property (
        WB_ACK_O && WB_ADR_I == RFC_OFS && !WB_WE_I |-> WB_DAT_O[6:3] == 4'h0)
        else $error("flag register reserved bits set");

    power_hold_a: assert property (
        $rose(RST_N) |-> CORE_RST && PORT_PRESET && PC_SP_CLR)
        else $error("power-on hold missing");

    // ==========================================
    // further checks: enable, source pick, count step, side effects
    ce_freeze_a: assert property (
        !CE |=> $stable(st_reg))
        else $error("state moved with enable low");

    sub_source_a: assert property (
        CE && wdt_on && !cnt_clr && !SUB_SRC_XTAL && !low_speed_rc_osc_tick
        |=> st_reg.cnt == $past(st_reg.cnt))
        else $error("count moved without an rc tick");

    count_step_a: assert property (
        CE && wdt_on && sub_tick && !cnt_clr
        |=> st_reg.cnt == $past(st_reg.cnt) + 18'h00001)
        else $error("enabled count did not step");

    preset_in_hold_a: assert property (
        PORT_PRESET |-> CORE_RST)
        else $error("port preset outside reset hold");

    sleep_keeps_a: assert property (
        CE && to_sleep && !fire && !wr_wdc
        |=> st_reg.wdc == $past(st_reg.wdc) && st_reg.hold == '0)
        else $error("sleep timeout touched other state");
endmodule
`default_nettype wire

// ### test/wdr_core_model.sv
`default_nettype none
// ==========================================
// core model: issues clear and halt instructions
module wdr_core_model (
    input wire logic MCLK,
    output logic CLEAR_WATCHDOG_INSTR,
    output logic HALT_INSTR,
    output logic SLEEP_MODE
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle core at time zero
    initial begin
        CLEAR_WATCHDOG_INSTR = 1'b0;
        HALT_INSTR = 1'b0;
        SLEEP_MODE = 1'b0;
    end
    // one-cycle refresh pulse; a halt pulse also restarts the count
    task clear_wdt();
        CLEAR_WATCHDOG_INSTR <= 1'b1;
        @(posedge MCLK);
        CLEAR_WATCHDOG_INSTR <= 1'b0;
    endtask
    // halt pulse, core then stays asleep
    task halt();
        HALT_INSTR <= 1'b1;
        SLEEP_MODE <= 1'b1;
        @(posedge MCLK);
        HALT_INSTR <= 1'b0;
    endtask
    // wake-up leaves sleep
    task wake();
        SLEEP_MODE <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### test/wdr_top_tb.sv
`default_nettype none
module wdr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wdr_pkg::*;
    logic mclk, rst_n, cyc, stb, we, xtal, rc, xsel, ext_n, low_voltage_reset, lvrk, ack;
    logic clr, halt, sleep, core_rst, pcsp, preset, to_f, pd_f, ce, keep;
    logic [3:0] adr, sel;
    logic [31:0] dat_i, dat_o, rd;
    logic [2:0] xc;
    logic [1:0] rcc;
    int fail_count, compares, n;

    // ==========================================
    // clocks: rc period 4 cycles, crystal period 6
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        rcc <= rcc + 2'h1;
        xc <= (xc == 3'h5) ? 3'h0 : xc + 3'h1;
    end
    assign rc = rcc[1];
    assign xtal = (xc > 3'h2);

    wdr_top #(.POR_DELAY_CYC(20)) i_wdr_top (.MCLK(mclk), .RST_N(rst_n), .CE(ce),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .LOW_SPEED_CRYSTAL(xtal),
        .LOW_SPEED_RC_OSC(rc), .SUB_SRC_XTAL(xsel), .CLEAR_WATCHDOG_INSTR(clr),
        .HALT_INSTR(halt), .SLEEP_MODE(sleep), .EXTERNAL_RESET_PIN_N(ext_n),
        .LOW_VOLTAGE_RESET(low_voltage_reset), .LVR_KEY_RESET(lvrk), .CORE_RST(core_rst),
        .PC_SP_CLR(pcsp), .PORT_PRESET(preset), .TIMEOUT_FLAG(to_f),
        .POWER_DOWN_FLAG(pd_f), .IDLE_SYSCLK_KEEP(keep));
    wdr_core_model i_wdr_core_model (.MCLK(mclk), .CLEAR_WATCHDOG_INSTR(clr),
        .HALT_INSTR(halt), .SLEEP_MODE(sleep));

    // ==========================================
    // helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // classic single wishbone cycle, waits for ack
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat_i <= {24'h0, d};
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (ack !== 1'b1) begin
            fail_count++;
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask
    // wait for reset hold to end, n cycles
    task settle();
        n = 0;
        while (core_rst !== 1'b0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        if (core_rst !== 1'b0) begin
            fail_count++;
        end
    endtask
    // wait for timeout flag, n cycles
    task run_to();
        n = 0;
        while (to_f !== 1'b1 && n < 70000) begin
            @(posedge mclk);
            n++;
        end
        if (to_f !== 1'b1) begin
            fail_count++;
        end
    endtask
    task give_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        {rst_n, cyc, stb, we, xsel, low_voltage_reset, lvrk} = 7'h0;
        {adr, sel, dat_i, rcc, xc, fail_count, compares} = '0;
        ext_n = 1'b1;
        ce = 1'b1;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk({core_rst, pcsp, preset}, 3'h7);
        settle();
        chk(n inside {[17:23]}, 1);
        chk(preset, 0);
        wb(0, WDC_OFS, 0);
        chk(rd, 32'h53);
        wb(1, RFC_OFS, 8'hff);
        chk(keep, 1);
        wb(0, RFC_OFS, 0);
        chk(rd, 32'h80);
        wb(1, RFC_OFS, 0);
        chk(keep, 0);
        wb(0, 4'hc, 0);
        chk(rd, 0);
        // sleep timeouts for three select codes
        for (int s = 0; s < 3; s++) begin
            int e;
            e = 4 << (8 + 2 * s);
            wb(1, WDC_OFS, {KEY_EN, s[2:0]});
            i_wdr_core_model.halt();
            @(posedge mclk);
            chk({pd_f, to_f}, 2'b10);
            run_to();
            chk(n inside {[e - 10:e + 10]}, 1);
            chk({pcsp, core_rst}, 2'b10);
            i_wdr_core_model.wake();
            i_wdr_core_model.clear_wdt();
        end
        // running timeout counted from the crystal
        xsel <= 1'b1;
        wb(1, WDC_OFS, {KEY_EN, 3'h0});
        i_wdr_core_model.clear_wdt();
        run_to();
        chk(n inside {[1524:1550]}, 1);
        chk(core_rst, 1);
        settle();
        xsel <= 1'b0;
        wb(0, STS_OFS, 0);
        chk(rd, 32'h2);
        // disabled key stops the count
        wb(1, WDC_OFS, {KEY_DIS, 3'h0});
        i_wdr_core_model.clear_wdt();
        repeat (1500) @(posedge mclk);
        chk({to_f, core_rst}, 0);
        wb(1, WDC_OFS, {KEY_EN, 3'h0});
        repeat (4) begin
            repeat (800) @(posedge mclk);
            i_wdr_core_model.clear_wdt();
        end
        chk({to_f, core_rst}, 0);
        // enable low freezes the count well past its timeout span
        ce <= 1'b0;
        repeat (1500) @(posedge mclk);
        chk({to_f, core_rst}, 0);
        ce <= 1'b1;
        // bad key leads to reset a few rc cycles later
        wb(1, WDC_OFS, 8'h00);
        n = 0;
        while (core_rst !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chk(n inside {[4:20]}, 1);
        chk(preset, 0);
        settle();
        wb(0, WDC_OFS, 0);
        chk(rd, 32'h53);
        wb(1, RFC_OFS, 8'h01);
        wb(0, RFC_OFS, 0);
        chk(rd, 32'h1);
        wb(1, RFC_OFS, 0);
        // low voltage, lvr key and pin sources
        for (int s = 0; s < 3; s++) begin
            {low_voltage_reset, lvrk, ext_n} <= {s == 0, s == 1, s != 2};
            @(posedge mclk);
            {low_voltage_reset, lvrk, ext_n} <= 3'b001;
            @(posedge mclk);
            chk(core_rst, 1);
            settle();
            wb(0, RFC_OFS, 0);
            chk(rd, (s == 0) ? 32'h4 : 32'h6);
        end
        give_verdict();
    end

    // hang guard
    initial begin
        repeat (90000) @(posedge mclk);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
